// ### pif_pkg.sv
// package of constants and types for the peripheral interrupt flag block
// Function
// - comparator input change sets flag two bit 6
// - first serial bus collision sets flag two bit 3
// - capture mode: timer capture sets flag two bit 0
// - compare mode: timer match sets flag two bit 0
// - pulse-width mode never sets that flag
// - serial two done sets flag three bit 7
// - second serial bus collision sets flag three bit 6
// - unimplemented bits read zero, ignore writes
// - flags set regardless of any enable bit
`default_nettype none
package pif_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_FLAGS_TWO   = 8'h00;
  localparam logic [7:0] OFS_FLAGS_THREE = 8'h04;
  localparam logic [7:0] OFS_MASK_TWO    = 8'h08;
  localparam logic [7:0] OFS_MASK_THREE  = 8'h0c;
  localparam logic [7:0] OFS_CTRL        = 8'h10;
  localparam logic [7:0] OFS_CMP_VALUE   = 8'h14;
  localparam logic [7:0] OFS_CAP_VALUE   = 8'h18;
  localparam logic [7:0] OFS_STATUS      = 8'h1c;

  // bit positions in peripheral_irq_flags_two
  localparam int BIT_OSC_FAIL   = 7;
  localparam int BIT_CMP_CHANGE = 6;
  localparam int BIT_BCL_ONE    = 3;
  localparam int BIT_CAPCOMP    = 0;
  // bit positions in peripheral_irq_flags_three
  localparam int BIT_SSP2_DONE  = 7;
  localparam int BIT_BCL_TWO    = 6;
  // ctrl and status fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int STAT_CMP_LVL   = 0;
  localparam int STAT_IRQ       = 1;

  // implemented bits; every other bit reads zero
  localparam logic [7:0] IMPL_TWO   = 8'hc9;
  localparam logic [7:0] IMPL_THREE = 8'hc0;

  // reset values
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [7:0]  RST_MASK  = 8'h00;
  localparam logic [15:0] RST_CMP   = 16'h0000;
  localparam logic [15:0] RST_CAP   = 16'h0000;
  // cycles after reset until the pin value reaches the third stage
  localparam logic [1:0]  SYNC_FILL = 2'h3;

  // operating mode of capcomp_unit_two
  typedef enum logic [1:0] {
    CC_OFF,
    CC_CAPTURE,
    CC_COMPARE,
    CC_PWM
  } pif_cc_mode_t;

  // one-cycle event pulses from same-clock peripheral logic
  typedef struct packed {
    logic osc_fail;   // fell back to internal_oscillator
    logic bcl_one;    // collision, first serial unit
    logic capture;    // capture edge of capcomp_unit_two
    logic ssp2_done;  // sync_serial_unit_two transfer done
    logic bcl_two;    // collision, sync_serial_unit_two
  } pif_evt_t;

endpackage
`default_nettype wire

// ### pif_flags.sv
// peripheral interrupt flag registers two and three with apb access
`default_nettype none
module pif_flags (
  input  wire logic              clk_sys_i,   // system clock, 50 mhz
  input  wire logic              rst_i,       // sync reset, active high
  input  wire logic              psel_i,      // apb select
  input  wire logic              penable_i,   // apb access phase
  input  wire logic              pwrite_i,    // apb write
  input  wire logic [7:0]        paddr_i,     // apb byte address
  input  wire logic [31:0]       pwdata_i,    // apb write data
  output logic                   pready_o,    // apb ready
  output logic [31:0]            prdata_o,    // apb read data
  output logic                   pslverr_o,   // apb error, unmapped
  input  wire pif_pkg::pif_evt_t evt_i,       // event pulses
  input  wire logic              cmp_in_i,    // comparator output, async
  input  wire logic [15:0]       timer_one_value_i, // running timer
  output logic [7:0]             peripheral_irq_flags_two_o,   // flags
  output logic [7:0]             peripheral_irq_flags_three_o, // flags
  output logic                   irq_o        // unmasked flag pending
);

  logic [7:0]            flags_two_q;
  logic [7:0]            flags_two_d;
  logic [7:0]            flags_three_q;
  logic [7:0]            flags_three_d;
  logic [7:0]            mask_two_q;
  logic [7:0]            mask_three_q;
  pif_pkg::pif_cc_mode_t mode_q;
  logic [15:0]           cmp_val_q;
  logic [15:0]           cap_val_q;
  logic                  cmp_s1_q;
  logic                  cmp_s2_q;
  logic                  cmp_s3_q;
  logic                  cmp_lvl_q;
  logic                  cmp_primed_q;
  logic [1:0]            cmp_fill_q;
  logic                  match_q;
  logic [31:0]           prdata_q;
  logic                  pslverr_q;

  // apb decode
  wire setup_rd  = psel_i && !penable_i && !pwrite_i;
  wire setup_any = psel_i && !penable_i;
  wire wr_acc    = psel_i && penable_i && pwrite_i;
  wire sel_f2    = paddr_i == pif_pkg::OFS_FLAGS_TWO;
  wire sel_f3    = paddr_i == pif_pkg::OFS_FLAGS_THREE;
  wire sel_m2    = paddr_i == pif_pkg::OFS_MASK_TWO;
  wire sel_m3    = paddr_i == pif_pkg::OFS_MASK_THREE;
  wire sel_ctl   = paddr_i == pif_pkg::OFS_CTRL;
  wire sel_cv    = paddr_i == pif_pkg::OFS_CMP_VALUE;
  wire sel_cap   = paddr_i == pif_pkg::OFS_CAP_VALUE;
  wire sel_st    = paddr_i == pif_pkg::OFS_STATUS;
  wire mapped    = sel_f2 | sel_f3 | sel_m2 | sel_m3 | sel_ctl | sel_cv
                 | sel_cap | sel_st;

  // write-one-to-clear strobes, unimplemented bits masked off
  // writes ignored there
  wire [7:0] clr_two   = (wr_acc && sel_f2) ?
                         (pwdata_i[7:0] & pif_pkg::IMPL_TWO) : 8'h00;
  wire [7:0] clr_three = (wr_acc && sel_f3) ?
                         (pwdata_i[7:0] & pif_pkg::IMPL_THREE) : 8'h00;

  // comparator change, filtered: second and third stage must agree
  wire cmp_stable = cmp_s2_q == cmp_s3_q;
  // reset zeros in the chain are not a settled level: a pin held high
  // through reset would otherwise raise a false change flag
  wire cmp_filled = cmp_fill_q == pif_pkg::SYNC_FILL;
  wire cmp_change = cmp_stable && cmp_primed_q && (cmp_s3_q != cmp_lvl_q);

  // compare match counted once on its rising edge, else a lasting
  // equality would refill the flag right after software clears it
  wire match_now   = timer_one_value_i == cmp_val_q;
  wire compare_hit = (mode_q == pif_pkg::CC_COMPARE) && match_now && !match_q;
  wire capture_hit = (mode_q == pif_pkg::CC_CAPTURE) && evt_i.capture;
  // pwm and off modes leave the flag alone
  wire capcomp_set = capture_hit || compare_hit;

  // hardware set vectors; enables play no part here
  // set ignores masks
  wire [7:0] set_two = 8'(
      ({7'h00, evt_i.osc_fail} << pif_pkg::BIT_OSC_FAIL) |
      ({7'h00, cmp_change}     << pif_pkg::BIT_CMP_CHANGE) |
      ({7'h00, evt_i.bcl_one}  << pif_pkg::BIT_BCL_ONE) |
      ({7'h00, capcomp_set}    << pif_pkg::BIT_CAPCOMP));
  wire [7:0] set_three = 8'(
      ({7'h00, evt_i.ssp2_done} << pif_pkg::BIT_SSP2_DONE) |
      ({7'h00, evt_i.bcl_two}   << pif_pkg::BIT_BCL_TWO));

  // set wins over a same-cycle clear
  assign flags_two_d   = (flags_two_q & ~clr_two) | set_two;
  assign flags_three_d = (flags_three_q & ~clr_three) | set_three;

  wire irq_pend = |(flags_two_q & mask_two_q) |
                  |(flags_three_q & mask_three_q);

  wire [31:0] rd_mux =
      sel_f2  ? {24'h000000, flags_two_q} :
      sel_f3  ? {24'h000000, flags_three_q} :
      sel_m2  ? {24'h000000, mask_two_q} :
      sel_m3  ? {24'h000000, mask_three_q} :
      sel_ctl ? {30'h00000000, mode_q} :
      sel_cv  ? {16'h0000, cmp_val_q} :
      sel_cap ? {16'h0000, cap_val_q} :
      sel_st  ? {30'h00000000, irq_pend, cmp_lvl_q} : 32'h00000000;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      flags_two_q   <= pif_pkg::RST_FLAGS;
      flags_three_q <= pif_pkg::RST_FLAGS;
    end
    else
    begin
      flags_two_q   <= flags_two_d;
      flags_three_q <= flags_three_d;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      mask_two_q   <= pif_pkg::RST_MASK;
      mask_three_q <= pif_pkg::RST_MASK;
      mode_q       <= pif_pkg::CC_OFF;
      cmp_val_q    <= pif_pkg::RST_CMP;
    end
    else if (wr_acc)
    begin
      // mask bits follow the flag layout
      if (sel_m2)
        mask_two_q <= pwdata_i[7:0] & pif_pkg::IMPL_TWO;
      if (sel_m3)
        mask_three_q <= pwdata_i[7:0] & pif_pkg::IMPL_THREE;
      if (sel_ctl)
        mode_q <= pif_pkg::pif_cc_mode_t'(
                    pwdata_i[pif_pkg::CTRL_MODE_LSB +: 2]);
      if (sel_cv)
        cmp_val_q <= pwdata_i[15:0];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cap_val_q <= pif_pkg::RST_CAP;
      match_q   <= 1'b0;
    end
    else
    begin
      if (capture_hit)
        cap_val_q <= timer_one_value_i;
      match_q <= match_now;
    end
  end

  // first stage feeds only the second
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      cmp_s1_q     <= 1'b0;
      cmp_s2_q     <= 1'b0;
      cmp_s3_q     <= 1'b0;
      cmp_lvl_q    <= 1'b0;
      cmp_primed_q <= 1'b0;
      cmp_fill_q   <= 2'h0;
    end
    else
    begin
      cmp_s1_q <= cmp_in_i;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
      if (!cmp_filled)
        cmp_fill_q <= cmp_fill_q + 2'h1;
      // first settled level after reset is taken without a flag
      if (cmp_stable && cmp_filled)
      begin
        cmp_lvl_q    <= cmp_s3_q;
        cmp_primed_q <= 1'b1;
      end
    end
  end

  // read data captured in setup, so access completes with no wait
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else if (setup_any)
    begin
      prdata_q  <= setup_rd ? rd_mux : 32'h00000000;
      pslverr_q <= !mapped;
    end
  end

  assign pready_o                     = 1'b1;
  assign prdata_o                     = prdata_q;
  assign pslverr_o                    = pslverr_q;
  assign peripheral_irq_flags_two_o   = flags_two_q;
  assign peripheral_irq_flags_three_o = flags_three_q;
  assign irq_o                        = irq_pend;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_cmp_flag;
    cmp_change |=> flags_two_q[pif_pkg::BIT_CMP_CHANGE];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag)
    else $error("comparator change did not set its flag");

  property p_bcl_one;
    evt_i.bcl_one && clr_two[pif_pkg::BIT_BCL_ONE]
      |=> flags_two_q[pif_pkg::BIT_BCL_ONE];
  endproperty
  a_bcl_one: assert property (p_bcl_one)
    else $error("collision lost against a same-cycle clear");

  property p_capture;
    capture_hit |=> flags_two_q[pif_pkg::BIT_CAPCOMP]
      && cap_val_q == $past(timer_one_value_i);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not set flag or hold timer value");

  property p_compare;
    mode_q == pif_pkg::CC_COMPARE && match_now && !match_q
      |=> flags_two_q[pif_pkg::BIT_CAPCOMP];
  endproperty
  a_compare: assert property (p_compare)
    else $error("compare match did not set the flag");

  property p_pwm_quiet;
    $rose(flags_two_q[pif_pkg::BIT_CAPCOMP])
      |-> $past(mode_q) != pif_pkg::CC_PWM;
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet)
    else $error("capcomp flag set while in pwm mode");

  property p_ssp2;
    evt_i.ssp2_done |=> flags_three_q[pif_pkg::BIT_SSP2_DONE];
  endproperty
  a_ssp2: assert property (p_ssp2)
    else $error("serial two completion did not set its flag");

  property p_bcl_two_hold;
    flags_three_q[pif_pkg::BIT_BCL_TWO] && !clr_three[pif_pkg::BIT_BCL_TWO]
      |=> flags_three_q[pif_pkg::BIT_BCL_TWO];
  endproperty
  a_bcl_two_hold: assert property (p_bcl_two_hold)
    else $error("collision two flag dropped without a clear");

  property p_unimpl;
    (flags_two_q & ~pif_pkg::IMPL_TWO) == 8'h00
      && (flags_three_q & ~pif_pkg::IMPL_THREE) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented flag bit reads one");

  property p_osc_fail;
    evt_i.osc_fail |=> flags_two_q[pif_pkg::BIT_OSC_FAIL] [*2]
      or (flags_two_q[pif_pkg::BIT_OSC_FAIL] ##1 $past(clr_two[7]));
  endproperty
  a_osc_fail: assert property (p_osc_fail)
    else $error("oscillator fail flag not set or lost");

  property p_no_mask;
    evt_i.bcl_two && mask_three_q == 8'h00 && mask_two_q == 8'h00
      && !(wr_acc && (sel_m2 || sel_m3))
      |=> flags_three_q[pif_pkg::BIT_BCL_TWO] && !irq_o;
  endproperty
  a_no_mask: assert property (p_no_mask)
    else $error("masked event failed to set flag or raised irq");

  property p_bcl_one_clr;
    wr_acc && sel_f2 && pwdata_i[pif_pkg::BIT_BCL_ONE] && !evt_i.bcl_one
      |=> !flags_two_q[pif_pkg::BIT_BCL_ONE];
  endproperty
  a_bcl_one_clr: assert property (p_bcl_one_clr)
    else $error("write of one did not clear collision flag");

  property p_bcl_two_src;
    $rose(flags_three_q[pif_pkg::BIT_BCL_TWO]) |-> $past(evt_i.bcl_two);
  endproperty
  a_bcl_two_src: assert property (p_bcl_two_src)
    else $error("collision two flag rose with no event");

  property p_cmp_settle;
    $fell(rst_i) |-> !cmp_change [*4];
  endproperty
  a_cmp_settle: assert property (p_cmp_settle)
    else $error("comparator flag raised by reset values");

  c_capture: cover property (capture_hit ##1 irq_o);
  c_compare: cover property (compare_hit);
  c_collide: cover property (evt_i.bcl_one && clr_two[3]);
  c_cmp_chg: cover property (cmp_change ##[1:20] wr_acc && sel_f2);

endmodule
`default_nettype wire

// ### pif_src_model.sv
// event source model: peripheral pulses, comparator level, timer
`default_nettype none
module pif_src_model (
  input  wire logic              clk_sys_i, // system clock
  input  wire logic              rst_i,     // sync reset
  input  wire pif_pkg::pif_evt_t fire_i,    // pulse requests
  input  wire logic              lvl_i,     // comparator level
  output var pif_pkg::pif_evt_t  evt_o,     // one-cycle pulses
  output logic                   cmp_o,     // comparator output
  output logic [15:0]            tmr_o      // free-running timer
);
  timeunit 1ns;
  timeprecision 1ns;
  // pulses launched on the clock, as same-clock logic would
  always_ff @(posedge clk_sys_i)
  begin
    evt_o <= rst_i ? '0 : fire_i;
    cmp_o <= lvl_i;
    tmr_o <= rst_i ? 16'h0000 : tmr_o + 16'h0001;
  end
endmodule
`default_nettype wire

// ### pif_flags_bench.sv
// self-checking bench of the peripheral interrupt flag block
`default_nettype none
module pif_flags_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_sys_i = 1'b0;
  logic              rst_i     = 1'b1;
  logic              psel_i    = 1'b0;
  logic              penable_i = 1'b0;
  logic              pwrite_i  = 1'b0;
  logic [7:0]        paddr_i   = 8'h00;
  logic [31:0]       pwdata_i  = 32'h0;
  logic              pready_o;
  logic [31:0]       prdata_o;
  logic              pslverr_o;
  pif_pkg::pif_evt_t fire      = '0;
  pif_pkg::pif_evt_t evt;
  logic              lvl       = 1'b0;
  logic              cmp;
  logic [15:0]       tmr;
  logic [15:0]       cap_seen  = 16'h0;
  logic [7:0]        f2;
  logic [7:0]        f3;
  logic              irq;
  logic [31:0]       rd;
  logic              er;
  int                error_cnt = 0;
  int                tests_run = 0;

  pif_src_model SRC (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .fire_i(fire),
    .lvl_i(lvl), .evt_o(evt), .cmp_o(cmp), .tmr_o(tmr));
  pif_flags DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .evt_i(evt), .cmp_in_i(cmp),
    .timer_one_value_i(tmr), .peripheral_irq_flags_two_o(f2),
    .peripheral_irq_flags_three_o(f3), .irq_o(irq));

  initial
  begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i)
  begin
    if (evt.capture)
      cap_seen <= tmr;
  end

  task automatic test_done;
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      error_cnt++;
    end
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 16);
    if (pready_o !== 1'b1)
    begin
      error_cnt++;
      test_done;
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic pulse(input logic [4:0] v);
    fire <= pif_pkg::pif_evt_t'(v);
    @(posedge clk_sys_i);
    fire <= '0;
    repeat (3) @(posedge clk_sys_i);
  endtask

  task automatic t_reset;
    for (int a = 0; a < 32; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0);
    end
  endtask

  task automatic t_err;
    apb(1'b1, 8'h20, 32'hffffffff);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
  endtask

  task automatic t_evt;
    logic [7:0] ofs [4] = '{8'h00, 8'h00, 8'h04, 8'h04};
    logic [7:0] bv [4]  = '{8'h80, 8'h08, 8'h80, 8'h40};
    logic [4:0] ev [4]  = '{5'h10, 5'h08, 5'h02, 5'h01};
    for (int i = 0; i < 4; i++)
    begin
      // masks are all clear here: flags still set
      pulse(ev[i]);
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, {24'h0, bv[i]});
      apb(1'b1, ofs[i] + 8'h08, {24'h0, bv[i]});
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, ofs[i], {24'h0, bv[i]});
      apb(1'b0, ofs[i], 32'h0);
      chk({rd[7:0], 23'h0, irq}, 32'h0);
      apb(1'b1, ofs[i] + 8'h08, 32'h0);
    end
  endtask

  task automatic t_unimpl;
    apb(1'b1, pif_pkg::OFS_MASK_TWO, 32'hffffffff);
    apb(1'b0, pif_pkg::OFS_MASK_TWO, 32'h0);
    chk(rd, {24'h0, pif_pkg::IMPL_TWO});
    apb(1'b1, pif_pkg::OFS_MASK_THREE, 32'hffffffff);
    apb(1'b0, pif_pkg::OFS_MASK_THREE, 32'h0);
    chk(rd, {24'h0, pif_pkg::IMPL_THREE});
    pulse(5'h1f);
    chk({16'h0, f2, f3}, 32'h88c0);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, pif_pkg::OFS_FLAGS_TWO, 32'hffffffff);
    apb(1'b1, pif_pkg::OFS_FLAGS_THREE, 32'hffffffff);
    chk({16'h0, f2, f3}, 32'h0);
    apb(1'b1, pif_pkg::OFS_MASK_TWO, 32'h0);
    apb(1'b1, pif_pkg::OFS_MASK_THREE, 32'h0);
  endtask

  task automatic t_cap;
    logic [1:0] off_modes [2] = '{pif_pkg::CC_OFF, pif_pkg::CC_PWM};
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, pif_pkg::OFS_CTRL, {30'h0, off_modes[i]});
      pulse(5'h04);
      chk({24'h0, f2}, 32'h0);
    end
    apb(1'b1, pif_pkg::OFS_CTRL, {30'h0, pif_pkg::CC_CAPTURE});
    pulse(5'h04);
    apb(1'b0, pif_pkg::OFS_FLAGS_TWO, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, pif_pkg::OFS_CAP_VALUE, 32'h0);
    chk(rd, {16'h0, cap_seen});
    // cleared before the next mode is armed
    apb(1'b1, pif_pkg::OFS_FLAGS_TWO, 32'h1);
    apb(1'b1, pif_pkg::OFS_CMP_VALUE, {16'h0, tmr + 16'h0028});
    apb(1'b1, pif_pkg::OFS_CTRL, {30'h0, pif_pkg::CC_COMPARE});
    repeat (60) @(posedge clk_sys_i);
    chk({24'h0, f2}, 32'h1);
    apb(1'b1, pif_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, pif_pkg::OFS_FLAGS_TWO, 32'h1);
  endtask

  task automatic t_cmpin;
    lvl <= ~lvl;
    repeat (10) @(posedge clk_sys_i);
    apb(1'b0, pif_pkg::OFS_FLAGS_TWO, 32'h0);
    chk(rd, 32'h40);
    apb(1'b1, pif_pkg::OFS_FLAGS_TWO, 32'h40);
    apb(1'b0, pif_pkg::OFS_STATUS, 32'h0);
    chk(rd, {31'h0, lvl});
    chk({24'h0, f2}, 32'h0);
  endtask

  // event and its clear land on one edge: the event must win
  task automatic t_race;
    fork
      pulse(5'h08);
      apb(1'b1, pif_pkg::OFS_FLAGS_TWO, 32'h00000008);
    join
    chk({24'h0, f2}, 32'h08);
    apb(1'b1, pif_pkg::OFS_FLAGS_TWO, 32'h00000008);
    chk({24'h0, f2}, 32'h0);
  endtask

  // mid-run reset with the comparator pin high: no stale or false flag
  task automatic t_rst_mid;
    apb(1'b1, pif_pkg::OFS_MASK_THREE, 32'h000000c0);
    pulse(5'h1f);
    chk({31'h0, irq}, 32'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    chk({24'h0, f2}, 32'h0);
    chk({24'h0, f3}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, pif_pkg::OFS_MASK_THREE, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, pif_pkg::OFS_STATUS, 32'h0);
    chk(rd, {31'h0, lvl});
  endtask

  initial
  begin
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // comparator adopts its first level before any test
    repeat (10) @(posedge clk_sys_i);
    t_reset;
    t_err;
    t_evt;
    t_unimpl;
    t_race;
    t_cap;
    t_cmpin;
    t_rst_mid;
    test_done;
  end
endmodule
`default_nettype wire
